//--- rtl/cdg_pkg.sv
package cdg_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] SRC_OFFSET = 12'h004;
    localparam logic [11:0] RISE_OFFSET = 12'h008;
    localparam logic [11:0] FALL_OFFSET = 12'h00c;
    localparam logic [11:0] STATUS_OFFSET = 12'h010;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_OEB_BIT = 6;
    localparam int CTRL_OEA_BIT = 5;
    localparam int CTRL_POLB_BIT = 4;
    localparam int CTRL_POLA_BIT = 3;
    localparam int CTRL_CS_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'hf9;

    // ----------------------------------------
    // Source and dead-band fields
    // ----------------------------------------
    localparam int SRC_W = 3;
    localparam logic [2:0] SRC_RESET = 3'h0;
    localparam logic [2:0] SRC_CMP = 3'h0;
    localparam logic [2:0] SRC_PWM1 = 3'h1;
    localparam logic [2:0] SRC_PWM2 = 3'h2;
    localparam logic [2:0] SRC_PWM3 = 3'h3;
    localparam int DB_W = 6;
    localparam logic [5:0] DB_RESET = 6'h00;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int OSC_MHZ = 16;
    localparam int OSC_DIV = CLK_MHZ / OSC_MHZ;

    // ----------------------------------------
    // Drive states and pin carrier
    // ----------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RISE_DB = 4'b0010,
        ST_HIGH = 4'b0100,
        ST_FALL_DB = 4'b1000
    } drive_e;

    typedef struct packed {
        logic primary;
        logic complement;
    } drive_s;

endpackage

//--- rtl/complementary_generator.sv
// Notes on behaviour
// - Two outputs, primary and complement, come from one selected input.
// - Clock select picks dead-band clock: system clock or 16 MHz oscillator enable.
// - Select one picks the oscillator, zero picks the system clock.
// - Three-bit input select chooses comparator or PWM channel one, two, three.
// - When enable is set both drives start cleared.
// - Each output has its own enable; cleared leaves the pin undriven.
// - With module enable clear, output enables and levels have no effect.
// - Polarity set gives active-high, cleared gives active-low.
// - Two independent seven-bit counters serve rising and falling edges.
// - Dead time counts clock periods up from zero to the programmed value.
// - Rising edge: complement off at once, count, then primary on.
// - Falling edge: primary off at once, count, then complement on.
// - Each dead-band setting spans zero to sixty-three counts.
// - A zero count inserts no dead time.
// - Input too short for the count leaves the incoming output off.
// - Input may be asynchronous; uncertainty stays within one dead-band clock.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module complementary_generator #(
    parameter int DB_WIDTH = cdg_pkg::DB_W,
    parameter int OSC_DIVIDE = cdg_pkg::OSC_DIV
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Waveform sources
    input wire logic COMPARATOR_SYNC_OUT,
    input wire logic PWM_CH1_OUT,
    input wire logic PWM_CH2_OUT,
    input wire logic PWM_CH3_OUT,
    // Output pins
    output logic PRIMARY_OUT,
    output logic PRIMARY_OUT_OE,
    output logic COMPLEMENT_OUT,
    output logic COMPLEMENT_OUT_OE
);

    if (DB_WIDTH != cdg_pkg::DB_W || OSC_DIVIDE < 1 || OSC_DIVIDE > 256) begin : g_bad_params
        $error("complementary_generator: unsupported parameters");
    end

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    logic rst_meta_q, rst_sync_q;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    // ----------------------------------------
    // APB register file
    // ----------------------------------------
    logic [7:0] ctrl_q;
    logic [2:0] src_q;
    logic [5:0] rise_q, fall_q;
    wire access = PSEL && PENABLE && PREADY;
    wire wr = access && PWRITE;
    wire hit_ctrl = PADDR == cdg_pkg::CTRL_OFFSET;
    wire hit_src = PADDR == cdg_pkg::SRC_OFFSET;
    wire hit_rise = PADDR == cdg_pkg::RISE_OFFSET;
    wire hit_fall = PADDR == cdg_pkg::FALL_OFFSET;
    wire hit_stat = PADDR == cdg_pkg::STATUS_OFFSET;
    wire mapped = hit_ctrl || hit_src || hit_rise || hit_fall || hit_stat;

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= cdg_pkg::CTRL_RESET;
            src_q <= cdg_pkg::SRC_RESET;
            rise_q <= cdg_pkg::DB_RESET;
            fall_q <= cdg_pkg::DB_RESET;
        end else if (wr) begin
            if (hit_ctrl) ctrl_q <= PWDATA[7:0] & cdg_pkg::CTRL_MASK;
            if (hit_src) src_q <= PWDATA[2:0];
            if (hit_rise) rise_q <= PWDATA[5:0];
            if (hit_fall) fall_q <= PWDATA[5:0];
        end
    end

    wire enable = ctrl_q[cdg_pkg::CTRL_EN_BIT];
    wire oe_a = ctrl_q[cdg_pkg::CTRL_OEA_BIT];
    wire oe_b = ctrl_q[cdg_pkg::CTRL_OEB_BIT];
    wire pol_a = ctrl_q[cdg_pkg::CTRL_POLA_BIT];
    wire pol_b = ctrl_q[cdg_pkg::CTRL_POLB_BIT];
    wire clk_sel = ctrl_q[cdg_pkg::CTRL_CS_BIT];

    // ----------------------------------------
    // Dead-band clock enable
    // ----------------------------------------
    logic [7:0] div_q;
    wire div_wrap = div_q == 8'(OSC_DIVIDE - 1);
    wire tick = clk_sel ? div_wrap : 1'b1;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_wrap ? 8'h00 : div_q + 8'h01;
        end
    end

    // ----------------------------------------
    // Source selection and synchroniser
    // ----------------------------------------
    logic src_sel;
    always_comb begin
        case (src_q)
            cdg_pkg::SRC_CMP: src_sel = COMPARATOR_SYNC_OUT;
            cdg_pkg::SRC_PWM1: src_sel = PWM_CH1_OUT;
            cdg_pkg::SRC_PWM2: src_sel = PWM_CH2_OUT;
            cdg_pkg::SRC_PWM3: src_sel = PWM_CH3_OUT;
            default: src_sel = 1'b0;
        endcase
    end

    logic in_meta_q, in_sync_q, in_prev_q;
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            in_meta_q <= 1'b0;
            in_sync_q <= 1'b0;
            in_prev_q <= 1'b0;
        end else begin
            in_meta_q <= src_sel;
            in_sync_q <= in_meta_q;
            if (tick) in_prev_q <= in_sync_q;
        end
    end
    wire rise_ev = tick && in_sync_q && !in_prev_q;
    wire fall_ev = tick && !in_sync_q && in_prev_q;

    // ----------------------------------------
    // Dead-band state machine
    // ----------------------------------------
    cdg_pkg::drive_e state_q, state_d;
    logic [6:0] rcnt_q, rcnt_d, fcnt_q, fcnt_d;
    cdg_pkg::drive_s drv_q, drv_d;
    wire rise_done = rcnt_q[5:0] == rise_q;
    wire fall_done = fcnt_q[5:0] == fall_q;

    always_comb begin
        state_d = state_q;
        rcnt_d = rcnt_q;
        fcnt_d = fcnt_q;
        drv_d = drv_q;
        if (!enable) begin
            state_d = cdg_pkg::ST_IDLE;
            drv_d = '0;
            rcnt_d = 7'h00;
            fcnt_d = 7'h00;
        end else if (rise_ev) begin
            drv_d.complement = 1'b0;
            rcnt_d = 7'h00;
            if (rise_q == cdg_pkg::DB_RESET) begin
                drv_d.primary = 1'b1;
                state_d = cdg_pkg::ST_HIGH;
            end else begin
                drv_d.primary = 1'b0;
                state_d = cdg_pkg::ST_RISE_DB;
            end
        end else if (fall_ev) begin
            drv_d.primary = 1'b0;
            fcnt_d = 7'h00;
            if (fall_q == cdg_pkg::DB_RESET) begin
                drv_d.complement = 1'b1;
                state_d = cdg_pkg::ST_IDLE;
            end else begin
                drv_d.complement = 1'b0;
                state_d = cdg_pkg::ST_FALL_DB;
            end
        end else if (tick) begin
            case (state_q)
                cdg_pkg::ST_RISE_DB: begin
                    rcnt_d = rcnt_q + 7'h01;
                    if (7'(rcnt_q + 7'h01) == {1'b0, rise_q}) begin
                        drv_d.primary = 1'b1;
                        state_d = cdg_pkg::ST_HIGH;
                    end
                end
                cdg_pkg::ST_FALL_DB: begin
                    fcnt_d = fcnt_q + 7'h01;
                    if (7'(fcnt_q + 7'h01) == {1'b0, fall_q}) begin
                        drv_d.complement = 1'b1;
                        state_d = cdg_pkg::ST_IDLE;
                    end
                end
                cdg_pkg::ST_IDLE, cdg_pkg::ST_HIGH: begin
                end
                default: state_d = cdg_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= cdg_pkg::ST_IDLE;
            rcnt_q <= 7'h00;
            fcnt_q <= 7'h00;
            drv_q <= '0;
        end else begin
            state_q <= state_d;
            rcnt_q <= rcnt_d;
            fcnt_q <= fcnt_d;
            drv_q <= drv_d;
        end
    end

    // ----------------------------------------
    // Pin drivers and read data
    // ----------------------------------------
    wire a_lvl = pol_a ? drv_d.primary : !drv_d.primary;
    wire b_lvl = pol_b ? drv_d.complement : !drv_d.complement;
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_ctrl) rdata = {24'h000000, ctrl_q};
        if (hit_src) rdata = {29'h00000000, src_q};
        if (hit_rise) rdata = {26'h0000000, rise_q};
        if (hit_fall) rdata = {26'h0000000, fall_q};
        if (hit_stat) rdata = {24'h000000, state_q, 2'b00, drv_q};
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PRIMARY_OUT <= 1'b0;
            COMPLEMENT_OUT <= 1'b0;
            PRIMARY_OUT_OE <= 1'b0;
            COMPLEMENT_OUT_OE <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PRIMARY_OUT <= enable && a_lvl;
            COMPLEMENT_OUT <= enable && b_lvl;
            PRIMARY_OUT_OE <= enable && oe_a;
            COMPLEMENT_OUT_OE <= enable && oe_b;
            PREADY <= PSEL && !PREADY;
            PSLVERR <= PSEL && !PREADY && !mapped;
            PRDATA <= (PSEL && !PWRITE) ? rdata : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_rise_zero;
        enable && rise_ev && rise_q == 6'h00;
    endsequence

    sequence s_rise_three;
        enable && !clk_sel && rise_ev && rise_q == 6'h03
        ##1 (!fall_ev && enable) [*3];
    endsequence

    sequence s_fall_five;
        enable && !clk_sel && fall_ev && fall_q == 6'h05
        ##1 (!rise_ev && enable) [*5];
    endsequence

    a_disabled_pins: assert property (@(posedge CLK) disable iff (!rst_n)
        !enable |=> !PRIMARY_OUT_OE && !COMPLEMENT_OUT_OE)
        else $error("pins enabled while module disabled");
    a_enable_clears: assert property (@(posedge CLK) disable iff (!rst_n)
        $rose(enable) |-> drv_q == 2'b00)
        else $error("drives not cleared at enable");
    a_rise_comp_off: assert property (@(posedge CLK) disable iff (!rst_n)
        enable && rise_ev |=> !drv_q.complement)
        else $error("complement not off at rising edge");
    a_fall_prim_off: assert property (@(posedge CLK) disable iff (!rst_n)
        enable && fall_ev |=> !drv_q.primary)
        else $error("primary not off at falling edge");
    a_zero_dead: assert property (@(posedge CLK) disable iff (!rst_n)
        s_rise_zero |=> drv_q.primary)
        else $error("zero dead time delayed primary");
    a_no_overlap: assert property (@(posedge CLK) disable iff (!rst_n)
        !(drv_q.primary && drv_q.complement))
        else $error("both drives active");
    a_rise_count: assert property (@(posedge CLK) disable iff (!rst_n)
        s_rise_three |=> drv_q.primary)
        else $error("rising dead time wrong length");
    a_fall_count: assert property (@(posedge CLK) disable iff (!rst_n)
        s_fall_five |=> drv_q.complement)
        else $error("falling dead time wrong length");
    a_rise_early: assert property (@(posedge CLK) disable iff (!rst_n)
        enable && rise_ev && rise_q != 6'h00 |=> !drv_q.primary)
        else $error("primary on before rising dead time");
    a_fall_early: assert property (@(posedge CLK) disable iff (!rst_n)
        enable && fall_ev && fall_q != 6'h00 |=> !drv_q.complement)
        else $error("complement on before falling dead time");
    a_rise_wait_off: assert property (@(posedge CLK) disable iff (!rst_n)
        state_q == cdg_pkg::ST_RISE_DB |-> !drv_q.primary)
        else $error("primary on during rising dead time");
    a_fall_wait_off: assert property (@(posedge CLK) disable iff (!rst_n)
        state_q == cdg_pkg::ST_FALL_DB |-> !drv_q.complement)
        else $error("complement on during falling dead time");
    a_idle_state: assert property (@(posedge CLK) disable iff (!rst_n)
        !enable |=> state_q == cdg_pkg::ST_IDLE)
        else $error("state not idle while disabled");
    a_disabled_idle: assert property (@(posedge CLK) disable iff (!rst_n)
        !enable |=> !PRIMARY_OUT && !COMPLEMENT_OUT)
        else $error("pin levels driven while module disabled");
    a_osc_spacing: assert property (@(posedge CLK) disable iff (!rst_n)
        clk_sel && tick |=> !tick || OSC_DIVIDE == 1 || $changed(ctrl_q))
        else $error("oscillator ticks too close");
    a_sync_delay: assert property (@(posedge CLK) disable iff (!rst_n)
        $past(rst_n, 2) |-> in_sync_q == $past(src_sel, 2))
        else $error("input synchroniser depth wrong");
    a_ready_pulse: assert property (@(posedge CLK) disable iff (!rst_n)
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");
    a_err_with_ready: assert property (@(posedge CLK) disable iff (!rst_n)
        PSLVERR |-> PREADY)
        else $error("slave error without ready");
    a_comp_pol: assert property (@(posedge CLK) disable iff (!rst_n)
        enable |=> COMPLEMENT_OUT == (pol_b == drv_q.complement) || $changed(ctrl_q))
        else $error("complement polarity wrong");
    a_primary_pol: assert property (@(posedge CLK) disable iff (!rst_n)
        enable |=> PRIMARY_OUT == (pol_a == drv_q.primary) || $changed(ctrl_q))
        else $error("primary polarity wrong");
    a_src_low: assert property (@(posedge CLK) disable iff (!rst_n)
        src_q > 3'h3 |-> !src_sel)
        else $error("unused source not low");

endmodule

`default_nettype wire

//--- verif/switch_model.sv
`timescale 1ns/1ps
`default_nettype none

module switch_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // High-side gate drive
    input wire logic high_gate,
    input wire logic high_oe,
    // Low-side gate drive
    input wire logic low_gate,
    input wire logic low_oe,
    // Shoot-through events seen
    output logic [7:0] overlap_count
);
    // ----------------------------------------
    // Gate sensing
    // ----------------------------------------
    // A released pin is pulled down, so the switch is off
    wire logic high_on = high_oe & high_gate;
    wire logic low_on = low_oe & low_gate;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overlap_count <= 8'h00;
        end else if (high_on & low_on) begin
            overlap_count <= overlap_count + 8'h01;
        end
    end
endmodule

`default_nettype wire

//--- verif/complementary_deadband_generator_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHECK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error %s expected %0h seen %0h", what, exp, got); end end

module complementary_deadband_generator_tb;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    localparam int OSC_D = 5;
    localparam logic [11:0] A_CTRL = cdg_pkg::CTRL_OFFSET;
    localparam logic [11:0] A_SRC = cdg_pkg::SRC_OFFSET;
    localparam logic [11:0] A_RISE = cdg_pkg::RISE_OFFSET;
    localparam logic [11:0] A_FALL = cdg_pkg::FALL_OFFSET;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] src = 4'h0;
    logic [31:0] prdata;
    logic pready, pslverr, pa, pa_oe, pb, pb_oe, seen;
    logic [7:0] overlaps;
    logic [31:0] rd;
    logic err;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int g, c0;

    always #2 clk = ~clk;

    complementary_generator #(.OSC_DIVIDE(OSC_D)) DUT (.CLK(clk), .RESET_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .COMPARATOR_SYNC_OUT(src[0]), .PWM_CH1_OUT(src[1]),
        .PWM_CH2_OUT(src[2]), .PWM_CH3_OUT(src[3]), .PRIMARY_OUT(pa), .PRIMARY_OUT_OE(pa_oe),
        .COMPLEMENT_OUT(pb), .COMPLEMENT_OUT_OE(pb_oe));

    switch_model partner (.clk(clk), .rst_n(rst_n), .high_gate(pa), .high_oe(pa_oe),
        .low_gate(pb), .low_oe(pb_oe), .overlap_count(overlaps));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task end_of_test;
        $display("Counts: %0d checks, %0d mismatches", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("Error timeout expected 0 seen 1");
            end_of_test();
        end
    end

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        `CHECK(name, exp, rd)
    endtask

    // Wait until a pin shows a level, counting cycles
    task until_lvl(input logic cmp, input logic lvl, output int c);
        c = 0;
        while (((cmp ? pb : pa) !== lvl) && c < 800) begin
            @(posedge clk);
            c++;
        end
    endtask

    // Move the PWM1 source; time the outgoing drop and the incoming rise
    task edge_gap(input logic lvl, output int gap);
        @(posedge clk);
        src <= lvl ? 4'h2 : 4'h0;
        until_lvl(lvl, 1'b0, c0);
        until_lvl(!lvl, 1'b1, gap);
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        `CHECK("pins after reset", 4'h0, {pa, pa_oe, pb, pb_oe})
        rd_chk(A_CTRL, 32'h0, "ctrl reset");
        rd_chk(A_SRC, 32'h0, "source reset");
        rd_chk(A_RISE, 32'h0, "rise reset");
        rd_chk(A_FALL, 32'h0, "fall reset");
        apb(1'b1, 12'h020, 32'h5a);
        `CHECK("unmapped error", 1'b1, err)
        `CHECK("unmapped data", 32'h0, rd)
        apb(1'b1, A_CTRL, 32'hff);
        rd_chk(A_CTRL, {24'h0, cdg_pkg::CTRL_MASK}, "ctrl mask");
        $display("Test registers done");
        // Output enables and polarity set, module disabled
        apb(1'b1, A_CTRL, 32'h78);
        src <= 4'hf;
        repeat (20) @(posedge clk);
        `CHECK("disabled pins", 4'h0, {pa, pa_oe, pb, pb_oe})
        src <= 4'h0;
        apb(1'b1, A_SRC, 32'h1);
        apb(1'b1, A_RISE, 32'h3);
        apb(1'b1, A_FALL, 32'h5);
        apb(1'b1, A_CTRL, 32'hf8);
        repeat (2) @(posedge clk);
        `CHECK("drives after enable", 4'h5, {pa, pa_oe, pb, pb_oe})
        $display("Test enable done");
        edge_gap(1'b1, g);
        edge_gap(1'b0, g);
        `CHECK("fall dead time", 5, g)
        edge_gap(1'b1, g);
        `CHECK("rise dead time", 3, g)
        `CHECK("edge to off", 1'b1, c0 >= 3 && c0 <= 5)
        rd_chk(cdg_pkg::STATUS_OFFSET, {24'h0, cdg_pkg::ST_HIGH, 4'h2}, "status high");
        apb(1'b1, A_RISE, 32'h0);
        edge_gap(1'b0, g);
        edge_gap(1'b1, g);
        `CHECK("zero dead time", 0, g)
        apb(1'b1, A_RISE, 32'h3f);
        edge_gap(1'b0, g);
        edge_gap(1'b1, g);
        `CHECK("max dead time", 63, g)
        $display("Test dead band done");
        apb(1'b1, A_RISE, 32'h14);
        edge_gap(1'b0, g);
        @(posedge clk);
        src <= 4'h2;
        repeat (8) @(posedge clk);
        src <= 4'h0;
        seen = 1'b0;
        repeat (40) begin
            @(posedge clk);
            seen = seen | pa;
        end
        `CHECK("short pulse", 1'b0, seen)
        apb(1'b1, A_CTRL, 32'hf9);
        apb(1'b1, A_RISE, 32'h2);
        edge_gap(1'b1, g);
        edge_gap(1'b0, g);
        edge_gap(1'b1, g);
        `CHECK("oscillator dead time", 1'b1, g >= 2 * OSC_D - 1 && g <= 2 * OSC_D + 1)
        $display("Test short pulse and clock select done");
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, A_CTRL, {24'h0, 1'b1, k[0], k[1], 5'h18});
            repeat (3) @(posedge clk);
            `CHECK("pin enables", {k[1], k[0]}, {pa_oe, pb_oe})
        end
        apb(1'b1, A_CTRL, 32'hf8);
        apb(1'b1, A_RISE, 32'h0);
        apb(1'b1, A_FALL, 32'h0);
        for (int k = 0; k < 8; k++) begin
            src <= 4'h0;
            apb(1'b1, A_SRC, k);
            repeat (10) @(posedge clk);
            src <= (k < 4) ? ~(4'h1 << k) : 4'hf;
            repeat (10) @(posedge clk);
            `CHECK("unselected source", 1'b0, pa)
            if (k < 4) begin
                src <= 4'hf;
                repeat (10) @(posedge clk);
                `CHECK("selected source", 1'b1, pa)
            end
        end
        `CHECK("shoot-through", 8'h00, overlaps)
        src <= 4'h0;
        apb(1'b1, A_CTRL, 32'h00);
        apb(1'b1, A_CTRL, 32'he0);
        repeat (3) @(posedge clk);
        `CHECK("active-low idle", 2'b11, {pa, pb})
        $display("Test sources and polarity done");
        end_of_test();
    end
endmodule

`default_nettype wire
